/* logic/wdtp_pkg.sv */
/*
 * Constants, register map and state type for the watchdog with prescaler.
 * Assumes one clock that stands for the quad-rate bus clock.
 */
`default_nettype none

package wdtp_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PRE_W = 12;
    localparam int WDG_W = 6;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_WDG_CLEAR = 16'hFFFF;
    localparam logic [15:0] ADDR_FIRST_CFG = 16'h001F;
    localparam logic [15:0] ADDR_RST_STATUS = 16'h0001;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CFG_DISABLE_BIT = 0;
    localparam int CFG_RATE_BIT = 1;
    localparam int CFG_PIN_EN_BIT = 2;
    localparam int STATUS_WDG_BIT = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_DISABLE = 1'b0;
    localparam logic RST_RATE = 1'b0;
    localparam logic RST_PIN_EN = 1'b0;

    // ------------------------------------------------------------
    // Timing counts, in quad-rate bus clock cycles
    // ------------------------------------------------------------
    localparam int LONG_CYCLES = 262128;
    localparam int SHORT_CYCLES = 8176;
    localparam int PIN_PULSE_CYCLES = 32;
    localparam int POR_CYCLES = 4096;
    localparam logic [11:0] PRE_TERM = 12'((LONG_CYCLES - 1) % (1 << PRE_W));
    localparam logic [5:0] WDG_TERM_LONG = 6'((LONG_CYCLES - 1) >> PRE_W);
    localparam logic [5:0] WDG_TERM_SHORT = 6'((SHORT_CYCLES - 1) >> PRE_W);
    localparam logic [5:0] PULSE_LAST = 6'(PIN_PULSE_CYCLES - 1);
    localparam logic [12:0] POR_LAST = 13'(POR_CYCLES - 1);

    // ------------------------------------------------------------
    // Whole state of the block
    // ------------------------------------------------------------
    typedef struct packed {
        logic [11:0] pre;
        logic [5:0] wdg;
        logic [12:0] por_cnt;
        logic por_done;
        logic [5:0] pulse_cnt;
        logic pulse_on;
        logic pin_oe_n;
        logic cfg_disable;
        logic cfg_rate;
        logic cfg_pin_en;
        logic cause_wdg;
        logic [7:0] rdata;
        logic wdg_reset;
    } wdtp_state_t;

endpackage : wdtp_pkg

`default_nettype wire

/* logic/wdtp_top.sv */
/*
 * Watchdog timer fed by a 12-bit prescale counter, with reset pin pulse,
 * reset cause flag and a small register port.
 * Assumes mclk is the quad-rate bus clock and that all control inputs
 * come from logic on the same clock.
 */
// Behaviour
// - A 12-bit prescale counter counts every clock and steps a 6-bit watchdog counter each time it wraps past 12'hFFF.
// - Without service the watchdog times out after 262128 or 8176 clocks, as rate select says.
// - Any write to the clear register zeroes the watchdog counter and prescale bits 11 to 4.
// - A timeout sets the cause flag and, with the pin enable set, drives the reset pin low 32 clocks.
// - The stop instruction clears the prescale counter.
// - A read of the clear register returns the low byte of the reset vector.
// - The prescale counter is cleared 4096 clocks after power up.
// - Any internal reset clears the prescale counter and the watchdog counter.
// - The disable output follows the disable bit of the first configuration register.
// - The counting chain runs on mclk, the quad-rate bus clock.
`timescale 1ns/10ps
`default_nettype none

module wdtp_top #(
    parameter logic [7:0] RESET_VECTOR_LO = 8'h00
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [wdtp_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [wdtp_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [wdtp_pkg::DATA_W-1:0] reg_rdata,
    // Core events
    input wire logic stop_exec,
    input wire logic internal_reset,
    // Reset outputs
    output logic wdg_reset,
    output logic rst_pin_out,
    output logic rst_pin_oe_n,
    output logic watchdog_disable
);
    import wdtp_pkg::*;

    wdtp_state_t cur_ff;
    wdtp_state_t nxt_cur;

    logic [5:0] wdg_term;
    logic timeout;
    logic clear_wr;

    always_comb
    begin
        nxt_cur = cur_ff;
        clear_wr = reg_wr && (reg_addr == ADDR_WDG_CLEAR);
        wdg_term = cur_ff.cfg_rate ? WDG_TERM_SHORT : WDG_TERM_LONG;
        timeout = !cur_ff.cfg_disable && !cur_ff.pulse_on
            && (cur_ff.wdg == wdg_term) && (cur_ff.pre == PRE_TERM);

        // ------------------------------------------------------------
        // Counting chain
        // ------------------------------------------------------------
        nxt_cur.pre = cur_ff.pre + 12'h001;
        if (cur_ff.pre == 12'hFFF)
        begin
            nxt_cur.wdg = cur_ff.wdg + 6'h01;
        end
        if (clear_wr)
        begin
            nxt_cur.wdg = 6'h00;
            nxt_cur.pre = {8'h00, cur_ff.pre[3:0] + 4'h1};
        end
        if (cur_ff.cfg_disable)
        begin
            nxt_cur.wdg = 6'h00;
        end
        if (stop_exec)
        begin
            nxt_cur.pre = 12'h000;
        end

        // ------------------------------------------------------------
        // Power-up delay
        // ------------------------------------------------------------
        if (!cur_ff.por_done)
        begin
            nxt_cur.por_cnt = cur_ff.por_cnt + 13'h0001;
            if (cur_ff.por_cnt == POR_LAST)
            begin
                nxt_cur.por_done = 1'b1;
                nxt_cur.pre = 12'h000;
            end
        end

        // ------------------------------------------------------------
        // Timeout and reset pulse
        // ------------------------------------------------------------
        if (cur_ff.pulse_on)
        begin
            nxt_cur.pulse_cnt = cur_ff.pulse_cnt + 6'h01;
            if (cur_ff.pulse_cnt == PULSE_LAST)
            begin
                nxt_cur.pulse_on = 1'b0;
                nxt_cur.wdg_reset = 1'b0;
                nxt_cur.pin_oe_n = 1'b1;
            end
        end
        if (internal_reset || cur_ff.pulse_on)
        begin
            nxt_cur.pre = 12'h000;
            nxt_cur.wdg = 6'h00;
        end
        if (timeout)
        begin
            nxt_cur.pulse_on = 1'b1;
            nxt_cur.pulse_cnt = 6'h00;
            nxt_cur.wdg_reset = 1'b1;
            nxt_cur.pin_oe_n = !cur_ff.cfg_pin_en;
            nxt_cur.pre = 12'h000;
            nxt_cur.wdg = 6'h00;
        end

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        if (reg_wr && (reg_addr == ADDR_FIRST_CFG))
        begin
            nxt_cur.cfg_disable = reg_wdata[CFG_DISABLE_BIT];
            nxt_cur.cfg_rate = reg_wdata[CFG_RATE_BIT];
            nxt_cur.cfg_pin_en = reg_wdata[CFG_PIN_EN_BIT];
        end
        if (reg_wr && (reg_addr == ADDR_RST_STATUS) && reg_wdata[STATUS_WDG_BIT])
        begin
            nxt_cur.cause_wdg = 1'b0;
        end
        if (timeout)
        begin
            nxt_cur.cause_wdg = 1'b1;
        end

        // ------------------------------------------------------------
        // Register reads
        // ------------------------------------------------------------
        nxt_cur.rdata = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                ADDR_WDG_CLEAR: nxt_cur.rdata = RESET_VECTOR_LO;
                ADDR_FIRST_CFG:
                begin
                    nxt_cur.rdata[CFG_DISABLE_BIT] = cur_ff.cfg_disable;
                    nxt_cur.rdata[CFG_RATE_BIT] = cur_ff.cfg_rate;
                    nxt_cur.rdata[CFG_PIN_EN_BIT] = cur_ff.cfg_pin_en;
                end
                ADDR_RST_STATUS: nxt_cur.rdata[STATUS_WDG_BIT] = cur_ff.cause_wdg;
                default: nxt_cur.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cur_ff <= '0;
            cur_ff.pin_oe_n <= 1'b1;
            cur_ff.cfg_disable <= RST_DISABLE;
            cur_ff.cfg_rate <= RST_RATE;
            cur_ff.cfg_pin_en <= RST_PIN_EN;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = cur_ff.rdata;
    assign wdg_reset = cur_ff.wdg_reset;
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe_n = cur_ff.pin_oe_n;
    assign watchdog_disable = cur_ff.cfg_disable;

endmodule : wdtp_top

`default_nettype wire

/* tb/wdtp_properties.sv */
/* Port checker for the watchdog with prescaler.
   Assumes it is bound to wdtp_top and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module wdtp_properties
    import wdtp_pkg::*;
#(
    parameter logic [7:0] RESET_VECTOR_LO = 8'h00
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [wdtp_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [wdtp_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [wdtp_pkg::DATA_W-1:0] reg_rdata,
    // Core events
    input wire logic stop_exec,
    input wire logic internal_reset,
    // Reset outputs
    input wire logic wdg_reset,
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe_n,
    input wire logic watchdog_disable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("rdata");
    a_vector_read: assert property
        (reg_rd && reg_addr == ADDR_WDG_CLEAR |=> reg_rdata == RESET_VECTOR_LO) else $error("vec");
    a_pulse_len: assert property
        ($rose(wdg_reset) |-> ##31 wdg_reset ##1 !wdg_reset) else $error("pulse length");
    a_pulse_hold: assert property ($rose(wdg_reset) |-> wdg_reset [*8]) else $error("pulse");
    a_pin_pair: assert property (!rst_pin_oe_n |-> wdg_reset) else $error("pin drive");
    a_pin_low: assert property (rst_pin_out == 1'b0) else $error("pin level");
    a_pin_release: assert property
        ($fell(wdg_reset) |-> rst_pin_oe_n) else $error("pin release");
    a_dis_follow: assert property
        (reg_wr && reg_addr == ADDR_FIRST_CFG && reg_wdata[CFG_DISABLE_BIT]
        |-> ##[1:2] watchdog_disable) else $error("disable");
    a_dis_clear: assert property
        (reg_wr && reg_addr == ADDR_FIRST_CFG && !reg_wdata[CFG_DISABLE_BIT]
        |=> !watchdog_disable) else $error("enable");
    a_dis_quiet: assert property
        ($past(watchdog_disable) |-> !$rose(wdg_reset)) else $error("dis");
    a_reset_clear: assert property
        (internal_reset |=> (!$rose(wdg_reset)) [*8]) else $error("internal reset");
endmodule : wdtp_properties
bind wdtp_top wdtp_properties #(.RESET_VECTOR_LO(RESET_VECTOR_LO)) u_wdtp_properties (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_exec(stop_exec),
    .internal_reset(internal_reset), .wdg_reset(wdg_reset), .rst_pin_out(rst_pin_out),
    .rst_pin_oe_n(rst_pin_oe_n), .watchdog_disable(watchdog_disable));
`default_nettype wire

/* tb/tb_top.sv */
/* Self-checking bench for the watchdog with prescaler.
   Assumes the bench drives every port of wdtp_top itself. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import wdtp_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic stop_exec = 1'b0;
    logic internal_reset = 1'b0;
    wire logic [7:0] reg_rdata;
    wire logic wdg_reset, rst_pin_out, rst_pin_oe_n, watchdog_disable;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    wdtp_top #(.RESET_VECTOR_LO(8'hA5)) u_wdtp_top (.mclk(mclk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .stop_exec(stop_exec), .internal_reset(internal_reset),
        .wdg_reset(wdg_reset), .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
        .watchdog_disable(watchdog_disable));
    always #10 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            n_fail++;
            finish_test();
        end
    end
    task automatic finish_test;
        if (n_fail == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task automatic chk8(logic [7:0] g, logic [7:0] e);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %0t value %h", $time, g);
        end
    endtask : chk8
    task automatic chkr(int c, int lo, int hi);
        samples_checked++;
        if (c < lo || c > hi)
        begin
            n_fail++;
            $display("mismatch %0t count %0d", $time, c);
        end
    endtask : chkr
    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [15:0] a, logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk8(reg_rdata, e);
    endtask : rd
    task automatic pulse_ir;
        @(posedge mclk);
        internal_reset <= 1'b1;
        @(posedge mclk);
        internal_reset <= 1'b0;
    endtask : pulse_ir
    task automatic measure(int lo, int hi, logic oe_n);
        int c;
        int n;
        c = 0;
        n = 0;
        while (c < hi + 4 && wdg_reset !== 1'b1)
        begin
            @(posedge mclk);
            #1 c++;
        end
        chkr(c, lo, hi);
        chk8({7'h00, rst_pin_oe_n}, {7'h00, oe_n});
        while (wdg_reset === 1'b1 && n < 40)
        begin
            @(posedge mclk);
            #1 n++;
        end
        chkr(n, 32, 32);
    endtask : measure
    task automatic quiet(int n);
        int c;
        c = 0;
        repeat (n)
        begin
            @(posedge mclk);
            #1 c += (wdg_reset !== 1'b0);
        end
        chkr(c, 0, 0);
    endtask : quiet
    task automatic por_check;
        @(posedge mclk);
        rst <= 1'b1;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        rd(ADDR_RST_STATUS, 8'h00);
        wr(ADDR_FIRST_CFG, 8'h06);
        repeat (996) @(posedge mclk);
        stop_exec <= 1'b1;
        @(posedge mclk);
        stop_exec <= 1'b0;
        measure(11269, 11273, 1'b0);
    endtask : por_check
    initial
    begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        wr(ADDR_WDG_CLEAR, 8'h00);
        rd(ADDR_FIRST_CFG, 8'h00);
        rd(ADDR_RST_STATUS, 8'h00);
        rd(ADDR_WDG_CLEAR, 8'hA5);
        rd(16'h0002, 8'h00);
        wr(ADDR_FIRST_CFG, 8'h07);
        rd(ADDR_FIRST_CFG, 8'h07);
        #1 chk8({7'h00, watchdog_disable}, 8'h01);
        repeat (4200) @(posedge mclk);
        // Short timeout with pin drive, cause flag set then cleared
        wr(ADDR_FIRST_CFG, 8'h06);
        pulse_ir();
        measure(8174, 8178, 1'b0);
        rd(ADDR_RST_STATUS, 8'h01);
        wr(ADDR_RST_STATUS, 8'h01);
        rd(ADDR_RST_STATUS, 8'h00);
        // Service write late in the interval
        pulse_ir();
        repeat (6000) @(posedge mclk);
        wr(ADDR_WDG_CLEAR, 8'h5A);
        measure(8158, 8178, 1'b0);
        // Stop clears only the prescaler, pin stays released
        wr(ADDR_FIRST_CFG, 8'h02);
        pulse_ir();
        repeat (5000) @(posedge mclk);
        stop_exec <= 1'b1;
        @(posedge mclk);
        stop_exec <= 1'b0;
        measure(4078, 4082, 1'b1);
        // Disabled, then long timeout not reached early
        wr(ADDR_FIRST_CFG, 8'h03);
        pulse_ir();
        quiet(9000);
        wr(ADDR_FIRST_CFG, 8'h00);
        pulse_ir();
        quiet(9000);
        // Reset in mid-run, then the power-up clear moves the timeout
        por_check();
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
